// *** pkg/ifri_cfg.svh ***
// Sizes, positions and counts for the fetch, rename and issue front end
`ifndef IFRI_CFG_SVH
`define IFRI_CFG_SVH
`define IFRI_TRK_DEPTH 20
`define IFRI_NLANE 4
`define IFRI_NPHYS 80
`define IFRI_NAREG 32
`define IFRI_LHIST_W 10
`define IFRI_LCNT_W 3
`define IFRI_GHIST_W 12
`define IFRI_GCNT_W 2
`define IFRI_PC_HI 11
`define IFRI_PC_LO 2
`define IFRI_ITB_DEPTH 128
`define IFRI_PAGE_SHIFT 13
`define IFRI_GH_STEP 3
`define IFRI_IQ_DEPTH 20
`define IFRI_FILL_LINES 2
`define IFRI_FETCH_STEP 48'h10
`define IFRI_LINE_STEP 44'h40
`endif

// *** pkg/ifri_pkg.sv ***
// Shared types for the fetch, rename and issue front end
`include "ifri_cfg.svh"
package ifri_pkg;
	typedef logic [47:0] ifri_va_type;
	typedef logic [6:0] ifri_preg_type;
	typedef logic [6:0] ifri_tag_type;
	typedef logic [4:0] ifri_areg_type;
	typedef logic [1:0][`IFRI_NAREG-1:0][6:0] ifri_map_type;
	typedef logic [1:0][`IFRI_NPHYS-1:0] ifri_use_type;
	typedef enum logic [1:0] {
		IFRI_SC_IDLE = 2'b01,
		IFRI_SC_FILL = 2'b10
	} ifri_sc_state_type;
	typedef struct packed {
		logic valid;
		ifri_va_type pc;
		logic [127:0] insn;
		logic [3:0] bp_bits;
		logic [10:0] line_pred;
		ifri_va_type ras_pc;
		logic [1:0] set_pred;
	} ifri_fetch_type;
	typedef struct packed {
		logic valid;
		logic is_fp;
		logic has_dst;
		logic lower;
		logic [1:0] unit_ok;
		ifri_areg_type dst;
		ifri_areg_type src_a;
		ifri_areg_type src_b;
		logic [31:0] insn;
	} ifri_dec_type;
	typedef struct packed {
		logic valid;
		logic lower;
		logic [1:0] unit_ok;
		ifri_tag_type tag;
		ifri_preg_type dst;
		ifri_preg_type old;
		ifri_preg_type sa;
		ifri_preg_type sb;
		logic [31:0] insn;
	} ifri_iq_type;
	typedef struct packed {
		logic [34:0] vpn;
		logic [30:0] pfn;
		logic [1:0] gh;
		logic [7:0] address_space_number;
		logic global_match_bit;
		logic [3:0] prot;
	} ifri_itb_type;
	typedef struct packed {
		logic valid;
		ifri_va_type pc;
		logic taken;
		logic mispred;
		logic [`IFRI_GHIST_W-1:0] ghist;
	} ifri_resolve_type;
	typedef struct packed {
		logic valid;
		logic exc;
		ifri_tag_type tag;
		ifri_va_type target;
	} ifri_recover_type;
	typedef struct packed {
		logic valid;
		logic is_fp;
		ifri_preg_type old;
	} ifri_retire_type;
	typedef struct packed {
		logic valid;
		logic cluster;
		ifri_preg_type preg;
	} ifri_wb_type;
endpackage : ifri_pkg

// *** verilog/ifri_branch_pred.sv ***
// Tournament branch predictor: local, global and choice tables
`timescale 1ns/1ps
`include "ifri_cfg.svh"
module ifri_branch_pred #(
	parameter int LHIST_W = `IFRI_LHIST_W,
	parameter int GHIST_W = `IFRI_GHIST_W
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic pred_valid,
	input ifri_pkg::ifri_va_type pred_pc,
	input ifri_pkg::ifri_resolve_type resolve,
	output logic pred_taken,
	output logic [GHIST_W-1:0] ghist
);
	localparam int LN = 1 << LHIST_W;
	localparam int GN = 1 << GHIST_W;
	localparam int LW = `IFRI_LCNT_W;
	localparam int GW = `IFRI_GCNT_W;
	logic [LHIST_W-1:0] lht_q [LN];
	logic [LW-1:0] lct_q [LN];
	logic [GW-1:0] gct_q [GN];
	logic [GW-1:0] cct_q [GN];
	logic [GHIST_W-1:0] gh_q;
	logic [LHIST_W-1:0] p_hist, r_hist, r_idx;
	logic p_loc, p_glb, r_loc, r_glb;
	logic [LW-1:0] lc;
	logic [GW-1:0] gc, cc;

	// Lookup: pc picks a history, the history picks a counter
	assign p_hist = lht_q[pred_pc[`IFRI_PC_HI:`IFRI_PC_LO]];
	assign p_loc = lct_q[p_hist][LW-1];
	assign p_glb = gct_q[gh_q][GW-1];
	assign pred_taken = cct_q[gh_q][GW-1] ? p_glb : p_loc;
	assign ghist = gh_q;
	assign r_idx = resolve.pc[`IFRI_PC_HI:`IFRI_PC_LO];
	assign r_hist = lht_q[r_idx];
	assign lc = lct_q[r_hist];
	assign gc = gct_q[resolve.ghist];
	assign cc = cct_q[resolve.ghist];
	assign r_loc = lc[LW-1];
	assign r_glb = gc[GW-1];

	// Speculative path history; a mispredict rebuilds it from the true outcome
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			gh_q <= '0;
		end else if (resolve.valid && resolve.mispred) begin
			gh_q <= {resolve.ghist[GHIST_W-2:0], resolve.taken};
		end else if (pred_valid) begin
			gh_q <= {gh_q[GHIST_W-2:0], pred_taken};
		end
	end

	// Training at resolve; counters saturate, choice leans to the right one
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < LN; i++) begin
				lht_q[i] <= '0;
				lct_q[i] <= '0;
			end
			for (int i = 0; i < GN; i++) begin
				gct_q[i] <= '0;
				cct_q[i] <= '0;
			end
		end else if (resolve.valid) begin
			lht_q[r_idx] <= {r_hist[LHIST_W-2:0], resolve.taken};
			if (resolve.taken && lc != '1) begin
				lct_q[r_hist] <= lc + 3'h1;
			end else if (!resolve.taken && lc != '0) begin
				lct_q[r_hist] <= lc - 3'h1;
			end
			if (resolve.taken && gc != '1) begin
				gct_q[resolve.ghist] <= gc + 2'h1;
			end else if (!resolve.taken && gc != '0) begin
				gct_q[resolve.ghist] <= gc - 2'h1;
			end
			if (r_loc != r_glb) begin
				if (r_glb == resolve.taken && cc != '1) begin
					cct_q[resolve.ghist] <= cc + 2'h1;
				end else if (r_loc == resolve.taken && cc != '0) begin
					cct_q[resolve.ghist] <= cc - 2'h1;
				end
			end
		end
	end

	AST_GHIST_SHIFT: assert property (@(posedge ref_clk) disable iff (!nrst)
		pred_valid && !(resolve.valid && resolve.mispred)
		|=> gh_q == {$past(gh_q[GHIST_W-2:0]), $past(pred_taken)})
		else $error("path history did not shift in prediction");
endmodule : ifri_branch_pred

// *** verilog/ifri_iq_arbiter.sv ***
// Age-ordered two-way pick for one pair of subclusters
`timescale 1ns/1ps
`include "ifri_cfg.svh"
module ifri_iq_arbiter #(
	parameter int N = `IFRI_IQ_DEPTH,
	parameter bit PREF_ONE = 1'b0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [N-1:0] req0,
	input wire logic [N-1:0] req1,
	input wire logic [4:0] head,
	output logic [1:0] gnt_v,
	output logic [1:0][4:0] gnt_idx
);
	localparam int PF = int'(PREF_ONE);

	// Walk from the oldest entry; each entry wins at most one slot
	always_comb begin
		int i;
		i = 0;
		gnt_v = '0;
		gnt_idx = '0;
		for (int k = 0; k < N; k++) begin
			i = (int'(head) + k) % N;
			if (!gnt_v[0] && !gnt_v[1] && req0[i] && req1[i]) begin
				gnt_v[PF] = 1'b1;
				gnt_idx[PF] = 5'(i);
			end else if (!gnt_v[0] && req0[i]) begin
				gnt_v[0] = 1'b1;
				gnt_idx[0] = 5'(i);
			end else if (!gnt_v[1] && req1[i]) begin
				gnt_v[1] = 1'b1;
				gnt_idx[1] = 5'(i);
			end
		end
	end

	AST_PREF_SLOT: assert property (@(posedge ref_clk) disable iff (!nrst)
		req0[head] && req1[head] |-> gnt_v[PF] && gnt_idx[PF] == head)
		else $error("oldest dual requester got the wrong slot");
	AST_OLDEST_FIRST: assert property (@(posedge ref_clk) disable iff (!nrst)
		req0[head] && !req1[head] |-> gnt_v[0] && gnt_idx[0] == head)
		else $error("oldest requester was passed over");
	AST_TWO_DISTINCT: assert property (@(posedge ref_clk) disable iff (!nrst)
		gnt_v == 2'h3 |-> gnt_idx[0] != gnt_idx[1])
		else $error("one entry granted both slots");
endmodule : ifri_iq_arbiter

// *** verilog/ifri_front_end.sv ***
// Fetch, translation, rename and integer issue front end
`timescale 1ns/1ps
`include "ifri_cfg.svh"
// Summary of operation
// - 20-slot fetch address table, 80 instructions
// - Local history table indexed by pc[11:2]
// - Local history indexes 3-bit counter table
// - Global history of last 12 outcomes
// - Global history indexes 2-bit counter table
// - Choice counters pick local or global
// - 128 associative translations, 1-512 page groups
// - Translation fills go round robin
// - Space number, global bit; lookup on miss
// - One aligned octaword fetched per cycle
// - Stack/set bits ride along; fills bypass buffer
// - Map sources, allocate destination, update map
// - Four instructions renamed per cycle
// - Old register freed only at retire
// - One-cycle map restore, fetch redirect
// - 20-entry queue issuing four per cycle
// - Request only when capable and ready
// - Upper and lower arbiters pick two each
// - Entry requests upper only or lower only
// - Oldest requester wins
// - Lower prefers slot zero, upper slot one
// - Two clusters, upper and lower each
// - Retire means all older finished cleanly
module ifri_front_end #(
	parameter int NLANE = `IFRI_NLANE,
	parameter int TRK = `IFRI_TRK_DEPTH,
	parameter int NPHYS = `IFRI_NPHYS,
	parameter int IQN = `IFRI_IQ_DEPTH,
	parameter int ITBN = `IFRI_ITB_DEPTH,
	parameter int NFILL = `IFRI_FILL_LINES
) (
	input wire logic ref_clk,
	input wire logic nrst,
	output ifri_pkg::ifri_va_type ic_req_pc,
	input ifri_pkg::ifri_fetch_type ic_resp,
	input wire logic ic_miss,
	input ifri_pkg::ifri_va_type ic_miss_pc,
	input wire logic [7:0] cur_asn,
	input wire logic itb_fill_valid,
	input ifri_pkg::ifri_itb_type itb_fill,
	output logic itb_miss,
	output logic fill_req_valid,
	output logic [43:0] fill_req_pa,
	input wire logic fill_data_valid,
	input wire logic [127:0] fill_data,
	output logic ic_fill_wr,
	output logic [127:0] ic_fill_data,
	output ifri_pkg::ifri_fetch_type fetch_out,
	output logic fetch_pred_taken,
	input ifri_pkg::ifri_resolve_type resolve,
	input ifri_pkg::ifri_recover_type recover,
	input ifri_pkg::ifri_dec_type [NLANE-1:0] dec_in,
	input ifri_pkg::ifri_va_type grp_pc,
	output logic ren_stall,
	output ifri_pkg::ifri_iq_type [NLANE-1:0] ren_out,
	input ifri_pkg::ifri_retire_type [NLANE-1:0] retire,
	input wire logic retire_slot_done,
	input ifri_pkg::ifri_wb_type [NLANE-1:0] wb,
	output ifri_pkg::ifri_iq_type [NLANE-1:0] issue_out
);
	localparam int NTAG = TRK * NLANE;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// ---- Fetch ----
	ifri_pkg::ifri_va_type pc_q, restart_pc, trk_pc;
	ifri_pkg::ifri_fetch_type fetch_q;
	logic bp_taken, pred_q;
	logic [4:0] rslot;
	logic [1:0] rlane;
	assign rslot = 5'(recover.tag / NLANE);
	assign rlane = 2'(recover.tag % NLANE);
	logic [4:0] slot_q, head_q;
	logic [5:0] tcnt_q;
	ifri_pkg::ifri_va_type trk_q [TRK];
	assign trk_pc = trk_q[rslot];
	// Exceptions restart at the faulting instruction, mispredicts at the target
	assign restart_pc = recover.exc ? trk_pc + 48'({rlane, 2'h0}) : recover.target;

	// Sequential octaword fetch; redirect wins, a miss holds the pc
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pc_q <= '0;
		end else if (recover.valid) begin
			pc_q <= {restart_pc[47:4], 4'h0};
		end else if (!ic_miss) begin
			pc_q <= pc_q + `IFRI_FETCH_STEP;
		end
	end
	assign ic_req_pc = pc_q;

	// Octaword with its prediction, line, stack and set bits kept together
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fetch_q <= '0;
			pred_q <= 1'b0;
		end else begin
			fetch_q <= ic_resp;
			fetch_q.valid <= ic_resp.valid && !recover.valid;
			pred_q <= bp_taken;
		end
	end
	assign fetch_out = fetch_q;
	assign fetch_pred_taken = pred_q;

	ifri_branch_pred u_bp (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pred_valid(ic_resp.valid),
		.pred_pc(ic_resp.pc),
		.resolve(resolve),
		.pred_taken(bp_taken),
		.ghist()
	);

	// ---- Translation buffer, consulted only on a cache miss ----
	ifri_pkg::ifri_itb_type tb_q [ITBN];
	logic [ITBN-1:0] tv_q;
	logic [6:0] rr_q;
	logic hit;
	logic [43:0] hit_pa;
	logic [34:0] mask;
	logic [34:0] mvpn;
	assign mvpn = ic_miss_pc[47:`IFRI_PAGE_SHIFT];

	// A group hint widens the match by three vpn bits per step
	always_comb begin
		hit = 1'b0;
		hit_pa = '0;
		mask = '1;
		for (int e = 0; e < ITBN; e++) begin
			mask = {35{1'b1}} << (`IFRI_GH_STEP * tb_q[e].gh);
			if (tv_q[e] && ((tb_q[e].vpn ^ mvpn) & mask) == '0 &&
				(tb_q[e].global_match_bit ||
				tb_q[e].address_space_number == cur_asn)) begin
				hit = 1'b1;
				hit_pa = {(tb_q[e].pfn & mask[30:0]) | (mvpn[30:0] & ~mask[30:0]),
					ic_miss_pc[`IFRI_PAGE_SHIFT-1:0]};
			end
		end
	end

	// Fills replace entries in strict rotation, no usage tracking
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tv_q <= '0;
			rr_q <= '0;
		end else if (itb_fill_valid) begin
			tb_q[rr_q] <= itb_fill;
			tv_q[rr_q] <= 1'b1;
			rr_q <= (rr_q == 7'(ITBN - 1)) ? 7'h0 : rr_q + 7'h1;
		end
	end

	// ---- Stream controller: requests lines, data goes straight to cache ----
	ifri_pkg::ifri_sc_state_type sc_q;
	logic [1:0] fcnt_q;
	logic miss_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sc_q <= ifri_pkg::IFRI_SC_IDLE;
			fcnt_q <= '0;
			fill_req_valid <= 1'b0;
			fill_req_pa <= '0;
			miss_q <= 1'b0;
		end else begin
			miss_q <= 1'b0;
			case (sc_q)
				ifri_pkg::IFRI_SC_IDLE: begin
					fill_req_valid <= 1'b0;
					if (ic_miss && hit) begin
						sc_q <= ifri_pkg::IFRI_SC_FILL;
						fill_req_valid <= 1'b1;
						fill_req_pa <= {hit_pa[43:6], 6'h00};
						fcnt_q <= 2'h1;
					end else if (ic_miss) begin
						miss_q <= 1'b1;
					end
				end
				ifri_pkg::IFRI_SC_FILL: begin
					fill_req_pa <= fill_req_pa + `IFRI_LINE_STEP;
					if (fcnt_q == 2'(NFILL)) begin
						fill_req_valid <= 1'b0;
						sc_q <= ifri_pkg::IFRI_SC_IDLE;
					end else begin
						fcnt_q <= fcnt_q + 2'h1;
					end
				end
				default: sc_q <= ifri_pkg::IFRI_SC_IDLE;
			endcase
		end
	end
	assign itb_miss = miss_q;

	// Returning line data is written to the cache the next cycle, unbuffered
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ic_fill_wr <= 1'b0;
			ic_fill_data <= '0;
		end else begin
			ic_fill_wr <= fill_data_valid;
			ic_fill_data <= fill_data;
		end
	end

	// ---- Rename ----
	ifri_pkg::ifri_map_type map_q, m, ck_sel;
	ifri_pkg::ifri_use_type use_q, u, rel;
	ifri_pkg::ifri_map_type ckm [NLANE];
	ifri_pkg::ifri_use_type cku [NLANE];
	ifri_pkg::ifri_map_type ck_map_q [NTAG];
	ifri_pkg::ifri_use_type ck_use_q [NTAG];
	ifri_pkg::ifri_iq_type [NLANE-1:0] ren;
	logic [4:0] iqcnt_q;
	logic stall, any_v, found;
	int f;
	assign ck_sel = ck_map_q[recover.tag];

	// Registers handed back by retirement, one per lane
	always_comb begin
		rel = '0;
		for (int l = 0; l < NLANE; l++) begin
			if (retire[l].valid) begin
				rel[retire[l].is_fp][retire[l].old] = 1'b1;
			end
		end
	end

	// Lanes see the map as left by older lanes of the same group
	always_comb begin
		m = map_q;
		u = use_q;
		f = 0;
		found = 1'b0;
		any_v = 1'b0;
		stall = recover.valid || tcnt_q == 6'(TRK) || iqcnt_q > 5'(IQN - NLANE);
		for (int l = 0; l < NLANE; l++) begin
			f = int'(dec_in[l].is_fp);
			ckm[l] = m;
			cku[l] = u;
			ren[l] = '0;
			ren[l].valid = dec_in[l].valid;
			ren[l].lower = dec_in[l].lower;
			ren[l].unit_ok = dec_in[l].unit_ok;
			ren[l].insn = dec_in[l].insn;
			ren[l].tag = 7'(int'(slot_q) * NLANE + l);
			ren[l].sa = m[f][dec_in[l].src_a];
			ren[l].sb = m[f][dec_in[l].src_b];
			any_v = any_v | dec_in[l].valid;
			if (dec_in[l].valid && dec_in[l].has_dst) begin
				found = 1'b0;
				ren[l].old = m[f][dec_in[l].dst];
				for (int p = 0; p < NPHYS; p++) begin
					if (!found && !u[f][p]) begin
						found = 1'b1;
						u[f][p] = 1'b1;
						ren[l].dst = 7'(p);
					end
				end
				if (!found) begin
					stall = 1'b1;
				end
				m[f][dec_in[l].dst] = ren[l].dst;
			end
		end
	end
	assign ren_stall = stall;

	// Map, free list and per-instruction checkpoints
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ren_out <= '0;
			for (int r = 0; r < 2; r++) begin
				for (int a = 0; a < `IFRI_NAREG; a++) begin
					map_q[r][a] <= 7'(a);
				end
				use_q[r] <= {{(NPHYS - `IFRI_NAREG){1'b0}}, {`IFRI_NAREG{1'b1}}};
			end
		end else if (recover.valid) begin
			map_q <= ck_sel;
			use_q <= ck_use_q[recover.tag] & use_q & ~rel;
			ren_out <= '0;
		end else if (!stall && any_v) begin
			map_q <= m;
			use_q <= u & ~rel;
			ren_out <= ren;
			for (int l = 0; l < NLANE; l++) begin
				ck_map_q[ren[l].tag] <= ckm[l];
				ck_use_q[ren[l].tag] <= cku[l];
			end
		end else begin
			use_q <= use_q & ~rel;
			ren_out <= '0;
		end
	end

	// Fetch address tracker: one slot per renamed group, freed at retire
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			slot_q <= '0;
			head_q <= '0;
			tcnt_q <= '0;
		end else begin
			if (retire_slot_done) begin
				head_q <= (head_q == 5'(TRK - 1)) ? 5'h0 : head_q + 5'h1;
			end
			if (recover.valid) begin
				slot_q <= (rslot == 5'(TRK - 1)) ? 5'h0 : rslot + 5'h1;
				tcnt_q <= 6'((int'(rslot) - int'(head_q) + TRK) % TRK + 1)
					- 6'(retire_slot_done);
			end else if (!stall && any_v) begin
				trk_q[slot_q] <= grp_pc;
				slot_q <= (slot_q == 5'(TRK - 1)) ? 5'h0 : slot_q + 5'h1;
				tcnt_q <= tcnt_q + 6'h1 - 6'(retire_slot_done);
			end else begin
				tcnt_q <= tcnt_q - 6'(retire_slot_done);
			end
		end
	end

	// ---- Integer issue queue ----
	ifri_pkg::ifri_iq_type iq_q [IQN];
	logic [4:0] iqh_q, iqt_q;
	logic [1:0][NPHYS-1:0] rdy_q;
	ifri_pkg::ifri_wb_type [NLANE-1:0] wbd_q;
	logic [1:0][IQN-1:0] upreq, loreq;
	logic [1:0] ugv, lgv;
	logic [1:0][4:0] ugi, lgi;

	// Availability per cluster; the far copy lags one cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdy_q <= {2{{(NPHYS - `IFRI_NAREG){1'b0}}, {`IFRI_NAREG{1'b1}}}};
			wbd_q <= '0;
		end else begin
			wbd_q <= wb;
			for (int l = 0; l < NLANE; l++) begin
				if (wb[l].valid) begin
					rdy_q[wb[l].cluster][wb[l].preg] <= 1'b1;
				end
				if (wbd_q[l].valid) begin
					rdy_q[~wbd_q[l].cluster][wbd_q[l].preg] <= 1'b1;
				end
				if (!stall && ren[l].valid && !dec_in[l].is_fp && dec_in[l].has_dst) begin
					rdy_q[0][ren[l].dst] <= 1'b0;
					rdy_q[1][ren[l].dst] <= 1'b0;
				end
			end
		end
	end

	// Four request lines per entry, one per subcluster
	for (genvar i = 0; i < IQN; i++) begin : g_req
		for (genvar c = 0; c < 2; c++) begin : g_cl
			logic ok;
			assign ok = iq_q[i].valid && iq_q[i].unit_ok[c] &&
				rdy_q[c][iq_q[i].sa] && rdy_q[c][iq_q[i].sb];
			assign upreq[c][i] = ok && !iq_q[i].lower;
			assign loreq[c][i] = ok && iq_q[i].lower;
		end
	end

	ifri_iq_arbiter #(.N(IQN), .PREF_ONE(1'b1)) u_arb_upper (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.req0(upreq[0]),
		.req1(upreq[1]),
		.head(iqh_q),
		.gnt_v(ugv),
		.gnt_idx(ugi)
	);
	ifri_iq_arbiter #(.N(IQN), .PREF_ONE(1'b0)) u_arb_lower (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.req0(loreq[0]),
		.req1(loreq[1]),
		.head(iqh_q),
		.gnt_v(lgv),
		.gnt_idx(lgi)
	);

	// Age of a tag counted from the oldest in-flight slot
	function automatic int age(input logic [6:0] t, input logic [4:0] h);
		age = (int'(t) - int'(h) * NLANE + NTAG) % NTAG;
	endfunction : age

	// Insert at tail, issue by grant, squash younger on recovery, drain holes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < IQN; i++) begin
				iq_q[i] <= '0;
			end
			iqh_q <= '0;
			iqt_q <= '0;
			iqcnt_q <= '0;
			issue_out <= '0;
		end else begin
			issue_out[0] <= ugv[0] ? iq_q[ugi[0]] : '0;
			issue_out[1] <= ugv[1] ? iq_q[ugi[1]] : '0;
			issue_out[2] <= lgv[0] ? iq_q[lgi[0]] : '0;
			issue_out[3] <= lgv[1] ? iq_q[lgi[1]] : '0;
			for (int s = 0; s < 2; s++) begin
				if (ugv[s]) begin
					iq_q[ugi[s]].valid <= 1'b0;
				end
				if (lgv[s]) begin
					iq_q[lgi[s]].valid <= 1'b0;
				end
			end
			if (recover.valid) begin
				for (int i = 0; i < IQN; i++) begin
					if (age(iq_q[i].tag, head_q) > age(recover.tag, head_q)) begin
						iq_q[i].valid <= 1'b0;
					end
				end
			end
			begin
				int k;
				int h;
				int n;
				k = int'(iqt_q);
				h = int'(iqh_q);
				n = int'(iqcnt_q);
				if (!stall) begin
					for (int l = 0; l < NLANE; l++) begin
						if (ren[l].valid) begin
							iq_q[k] <= ren[l];
							k = (k + 1) % IQN;
							n = n + 1;
						end
					end
				end
				for (int l = 0; l < NLANE; l++) begin
					if (iqcnt_q > 5'(l) && !iq_q[h].valid) begin
						h = (h + 1) % IQN;
						n = n - 1;
					end
				end
				iqt_q <= 5'(k);
				iqh_q <= 5'(h);
				iqcnt_q <= 5'(n);
			end
		end
	end

	// ---- Checks ----
	sequence s_fill_start;
		sc_q == ifri_pkg::IFRI_SC_IDLE && ic_miss && hit;
	endsequence
	sequence s_fill_run;
		fill_req_valid [*2] ##1 !fill_req_valid;
	endsequence
	AST_FILL_BURST: assert property (s_fill_start |=> s_fill_run)
		else $error("stream controller line requests wrong");
	AST_MISS_ONLY: assert property (itb_miss |-> $past(ic_miss) && !$past(hit))
		else $error("translation miss without cache miss");
	// Sampled reset gates the start so the release edge opens no attempt
	AST_FETCH_STEP: assert property (nrst && !recover.valid && !ic_miss |=>
		pc_q == $past(pc_q) + `IFRI_FETCH_STEP)
		else $error("fetch pc did not advance one octaword");
	AST_RR_FILL: assert property (itb_fill_valid && rr_q != 7'(ITBN - 1) |=>
		rr_q == $past(rr_q) + 7'h1)
		else $error("translation fill pointer not round robin");
	AST_NO_EARLY_FREE: assert property (!recover.valid && rel == '0 |=>
		(~use_q & $past(use_q)) == '0)
		else $error("register freed without retirement");
	AST_MAP_RESTORE: assert property (recover.valid |=> map_q == $past(ck_sel))
		else $error("rename map not restored in one cycle");
	AST_TRK_BOUND: assert property (tcnt_q <= 6'(TRK))
		else $error("fetch slot tracker overfilled");
	AST_ISSUE_GRANT: assert property (lgv[0] |=> issue_out[2].valid &&
		issue_out[2].lower)
		else $error("lower slot zero grant did not issue");
	AST_QUEUE_BOUND: assert property (iqcnt_q <= 5'(IQN))
		else $error("issue queue overfilled");
endmodule : ifri_front_end

// *** tb/ifri_icache_model.sv ***
// Instruction cache model that answers each fetch address in the same cycle
`timescale 1ns/1ps
module ifri_icache_model (
	input ifri_pkg::ifri_va_type req_pc,
	output ifri_pkg::ifri_fetch_type resp
);
	// Contents come from the address so the bench can predict every field
	always_comb begin
		resp = '0;
		resp.valid = 1'b1;
		resp.pc = req_pc;
		resp.insn = {4{req_pc[31:0]}};
		resp.ras_pc = ~req_pc;
		resp.set_pred = req_pc[5:4];
	end
endmodule : ifri_icache_model

// *** tb/tb_instruction_fetch_rename_issue.sv ***
// Self-checking bench for the fetch, rename and issue front end
`timescale 1ns/1ps
module tb_instruction_fetch_rename_issue;
	logic ref_clk, nrst, ic_miss, itb_fill_valid, fill_data_valid, retire_slot_done;
	logic itb_miss, fill_req_valid, ic_fill_wr, fetch_pred_taken, ren_stall;
	logic [7:0] cur_asn;
	logic [43:0] fill_req_pa;
	logic [127:0] fill_data, ic_fill_data;
	ifri_pkg::ifri_va_type ic_req_pc, ic_miss_pc, grp_pc, pc;
	ifri_pkg::ifri_fetch_type ic_resp, fetch_out;
	ifri_pkg::ifri_itb_type itb_fill;
	ifri_pkg::ifri_resolve_type resolve;
	ifri_pkg::ifri_recover_type recover;
	ifri_pkg::ifri_dec_type [3:0] dec_in;
	ifri_pkg::ifri_iq_type [3:0] ren_out, issue_out;
	ifri_pkg::ifri_retire_type [3:0] retire;
	ifri_pkg::ifri_wb_type [3:0] wb;
	int mismatches, compares;
	ifri_front_end dut (
		.ref_clk(ref_clk), .nrst(nrst), .ic_req_pc(ic_req_pc), .ic_resp(ic_resp),
		.ic_miss(ic_miss), .ic_miss_pc(ic_miss_pc), .cur_asn(cur_asn),
		.itb_fill_valid(itb_fill_valid), .itb_fill(itb_fill), .itb_miss(itb_miss),
		.fill_req_valid(fill_req_valid), .fill_req_pa(fill_req_pa),
		.fill_data_valid(fill_data_valid), .fill_data(fill_data), .ic_fill_wr(ic_fill_wr),
		.ic_fill_data(ic_fill_data), .fetch_out(fetch_out), .fetch_pred_taken(fetch_pred_taken),
		.resolve(resolve), .recover(recover), .dec_in(dec_in), .grp_pc(grp_pc),
		.ren_stall(ren_stall), .ren_out(ren_out), .retire(retire),
		.retire_slot_done(retire_slot_done), .wb(wb), .issue_out(issue_out)
	);
	ifri_icache_model icm (.req_pc(ic_req_pc), .resp(ic_resp));
	// Free-running core clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict;
		if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// Registered fetch copies the cache answer with its side bits
	task automatic t_fetch;
		@(posedge ref_clk);
		#1 pc = ic_req_pc;
		chk(pc[3:0], 4'h0);
		@(posedge ref_clk);
		#1 chk(fetch_out.pc, pc);
		chk(fetch_out.ras_pc, 48'(~pc));
		chk(fetch_pred_taken, 1'b0);
	endtask : t_fetch
	// Empty buffer, then a wrong space number, miss; a match starts a two-line burst
	task automatic t_itb;
		@(posedge ref_clk);
		ic_miss <= 1'b1;
		ic_miss_pc <= 48'h2040;
		itb_fill_valid <= 1'b1;
		itb_fill <= '{vpn: 35'h1, pfn: 31'h5, address_space_number: 8'h03, default: '0};
		@(posedge ref_clk);
		itb_fill_valid <= 1'b0;
		#1 chk(itb_miss, 1'b1);
		@(posedge ref_clk);
		cur_asn <= 8'h03;
		#1 chk(itb_miss, 1'b1);
		chk(fill_req_valid, 1'b0);
		@(posedge ref_clk);
		ic_miss <= 1'b0;
		#1 chk(itb_miss, 1'b0);
		chk(fill_req_valid, 1'b1);
		chk(fill_req_pa, 44'hA040);
		@(posedge ref_clk);
		#1 chk(fill_req_pa, 44'hA080);
		chk(fill_req_valid, 1'b1);
		@(posedge ref_clk);
		#1 chk(fill_req_valid, 1'b0);
	endtask : t_itb
	// Line data goes straight to the cache one cycle later
	task automatic t_fill;
		@(posedge ref_clk);
		fill_data_valid <= 1'b1;
		fill_data <= 128'hA5;
		@(posedge ref_clk);
		fill_data_valid <= 1'b0;
		#1 chk(ic_fill_wr, 1'b1);
		chk(ic_fill_data, 128'hA5);
	endtask : t_fill
	// Chained four-wide group; tags only predictable with an empty tracker
	task automatic t_rename(input bit check_tag);
		ifri_pkg::ifri_dec_type d;
		d = '0;
		d.valid = 1'b1;
		d.has_dst = 1'b1;
		d.unit_ok = 2'b11;
		@(posedge ref_clk);
		grp_pc <= 48'h3010;
		for (int l = 0; l < 4; l++) begin
			d.dst = 5'(l + 1);
			d.src_a = 5'(l);
			dec_in[l] <= d;
		end
		#1 chk(ren_stall, 1'b0);
		@(posedge ref_clk);
		dec_in <= '0;
		#1 chk(ren_out[0].sa, 7'h0);
		for (int l = 0; l < 4; l++) begin
			chk(ren_out[l].valid, 1'b1);
			chk(ren_out[l].old, 7'(l + 1));
			chk(ren_out[l].dst >= 7'h20, 1'b1);
			if (l > 0) chk(ren_out[l].sa, ren_out[l - 1].dst);
			if (check_tag) chk(ren_out[l].tag, 7'(l));
		end
	endtask : t_rename
	// Mispredict goes to the target; an exception then restarts at the tracked pc
	task automatic t_recover;
		@(posedge ref_clk);
		recover <= '{valid: 1'b1, exc: 1'b0, tag: 7'h0, target: 48'h2000};
		@(posedge ref_clk);
		recover <= '{valid: 1'b1, exc: 1'b1, tag: 7'h0, target: 48'h0};
		#1 chk(ic_req_pc, 48'h2000);
		chk(fetch_out.valid, 1'b0);
		@(posedge ref_clk);
		recover <= '0;
		#1 chk(ic_req_pc, 48'h3010);
	endtask : t_recover
	// Two lower and two upper entries ready at once: age order, lower zero, upper one
	task automatic t_issue;
		ifri_pkg::ifri_dec_type d;
		d = '0;
		d.valid = 1'b1;
		d.unit_ok = 2'b11;
		@(posedge ref_clk);
		for (int l = 0; l < 4; l++) begin
			d.lower = (l < 2);
			d.insn = 32'(l + 1);
			dec_in[l] <= d;
		end
		@(posedge ref_clk);
		dec_in <= '0;
		@(posedge ref_clk);
		#1 chk(issue_out[2].insn, 32'h1);
		chk(issue_out[3].insn, 32'h2);
		chk(issue_out[1].insn, 32'h3);
		chk(issue_out[0].insn, 32'h4);
		chk(issue_out[2].lower, 1'b1);
	endtask : t_issue
	// Watchdog cuts a hang short
	initial begin
		repeat (3000) @(posedge ref_clk);
		mismatches++;
		print_verdict();
	end
	// Main sequence
	initial begin
		{nrst, ic_miss, itb_fill_valid, fill_data_valid, retire_slot_done} = '0;
		{cur_asn, fill_data, ic_miss_pc, grp_pc, itb_fill, resolve} = '0;
		{recover, dec_in, retire, wb} = '0;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		t_rename(1'b1);
		t_fetch();
		t_itb();
		t_fill();
		t_recover();
		t_rename(1'b0);
		t_issue();
		print_verdict();
	end
endmodule : tb_instruction_fetch_rename_issue
